// ### src/csc_pkg.sv
package csc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_FRU = 6'h08;
	localparam logic [5:0] IDX_CK1 = 6'h09;
	localparam logic [5:0] IDX_CK2 = 6'h0A;
	localparam logic [5:0] IDX_CK3 = 6'h0B;
	localparam logic [5:0] IDX_FR3 = 6'h0F;
	localparam logic [5:0] IDX_FR4 = 6'h10;
	localparam logic [5:0] IDX_SDI = 6'h15;
	localparam logic [5:0] IDX_SYM = 6'h16;
	localparam logic [5:0] IDX_CTRL = 6'h18;
	localparam logic [5:0] IDX_STAT = 6'h19;

	// Sense bit n counts from the most significant bit
	localparam int B0 = 7;
	localparam int B1 = 6;
	localparam int B2 = 5;
	localparam int B3 = 4;
	localparam int B4 = 3;
	localparam int B5 = 2;
	localparam int B6 = 1;
	localparam int B7 = 0;

	// Control and status fields
	localparam int CTRL_INHIBIT = 0;
	localparam int STAT_FROZEN = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// Good-parity idle value of the ALU bus in the synchroniser after reset
	localparam logic [8:0] ALU_IDLE = 9'h001;

	// Director-side check and state lines
	typedef struct packed {
		logic t0;
		logic [4:0] grp_dec;
		logic ext_op;
		logic solid_chk;
		logic store_cycle;
		logic ros_exec;
		logic [8:0] alu_bus;
		logic in_par_err;
		logic [5:0] ext_addr;
		logic ls_addr_chk;
		logic gate_chk;
		logic dbl_bit_err;
		logic bad_clk_seq;
		logic [3:0] mnt_decode;
		logic [3:0] ring_gates;
		logic [2:0] refresh_faults;
		logic start_req;
		logic stop_req;
		logic drc_par_err;
		logic inv_addr;
		logic cs_addr_par;
		logic cs_data_par;
		logic fetch_in_par;
		logic reg_in_par;
		logic [2:0] cpu_faults;
		logic [4:0] cpu_status;
		logic [2:0] cs_addr_hi;
		logic [7:0] id_sw;
	} csc_pins_t;

	typedef struct packed {
		csc_pins_t sync1;
		csc_pins_t sync2;
		logic frozen;
		logic inhibit;
		logic [7:0] fru;
		logic [7:0] ck1;
		logic [7:0] ck2;
		logic [7:0] ck3;
		logic [7:0] fr3;
		logic [7:0] fr4;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic wstrb0;
	} csc_state_t;

endpackage

// ### src/csc_sense_capture.sv
// Behaviour
// R1: Group-select flags follow each decoder's decode
// R2: Byte 8 bit 4 marks external register operation
// R3: Byte 8 bit 5 records unrecoverable solid check
// R4: Byte 8 bit 6 captures store cycle
// R5: Byte 8 bit 7 captures read-only store execution
// R6: ALU bus parity checked each time-zero phase
// R7: Input parity error propagates unless inhibited
// R8: External address parity checked each time-zero
// R9: Sequence card flags bad ALU bus parity
// R10: Local store or gating error sets bit 3
// R11: Any byte 11 check sets chip summary
// R12: Uncorrectable double-bit fetch sets bit 5
// R13: Bad clock sequence sets bit 6; 7 unused
// R14: Multiple maintenance decodes set byte 10 bit 0
// R15: Overlapping clock ring gates set bit 1
// R16: Any refresh or key fault sets bit 2
// R17: Start with stop together sets bit 3
// R18: Refresh parity bit 4, invalid address bit 5
// R19: Store address bit 6, write data bit 7
// R20: Input parity on fetch or register gating
// R21: Processor faults bit 2, status bits 3-7
// R22: Capture address bits; identifier reads switches
// R23: Snapshot frozen until check byte one read
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module csc_sense_capture (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Director check and state lines
	input wire csc_pkg::csc_pins_t pins,
	// Capture status
	output logic sense_frozen,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	csc_pkg::csc_state_t q;
	csc_pkg::csc_state_t d;
	csc_pkg::csc_pins_t p;
	logic [7:0] ck1_n;
	logic [7:0] ck2_n;
	logic [7:0] ck3_n;
	logic [7:0] fru_n;
	logic alu_bad;
	logic any_new;
	logic release_rd;
	logic ar_ok;
	logic [5:0] ridx;
	logic [5:0] widx;

	function automatic logic multi(input logic [3:0] v);
		multi = (v & (v - 4'h1)) != 4'h0;
	endfunction

	always_comb
	begin
		d = q;
		p = q.sync2;
		// Pins pass two flops first
		d.sync1 = pins;
		d.sync2 = q.sync1;

		fru_n = csc_pkg::BYTE_RST;
		fru_n[csc_pkg::B0] = p.grp_dec[0]; // [R1]
		fru_n[csc_pkg::B1] = p.grp_dec[1]; // [R1]
		fru_n[csc_pkg::B2] = p.grp_dec[2]; // [R1]
		fru_n[csc_pkg::B3] = p.grp_dec[3]; // [R1]
		fru_n[csc_pkg::B4] = p.ext_op; // [R2]
		fru_n[csc_pkg::B5] = p.solid_chk; // [R3]
		fru_n[csc_pkg::B6] = p.store_cycle; // [R4]
		fru_n[csc_pkg::B7] = p.ros_exec; // [R5]

		// Bad input parity shows on the ALU bus unless inhibited
		alu_bad = ~(^p.alu_bus) | (p.in_par_err & ~q.inhibit); // [R7]

		ck3_n = csc_pkg::BYTE_RST;
		ck3_n[csc_pkg::B0] = p.fetch_in_par; // [R20]
		ck3_n[csc_pkg::B1] = p.reg_in_par; // [R20]
		ck3_n[csc_pkg::B2] = |p.cpu_faults; // [R21]

		ck1_n = csc_pkg::BYTE_RST;
		ck1_n[csc_pkg::B0] = p.t0 & alu_bad; // [R6]
		ck1_n[csc_pkg::B1] = p.t0 & ~(^p.ext_addr); // [R8]
		ck1_n[csc_pkg::B2] = alu_bad; // [R9]
		ck1_n[csc_pkg::B3] = p.ls_addr_chk | p.gate_chk; // [R10]
		ck1_n[csc_pkg::B4] = ck3_n[csc_pkg::B0] | ck3_n[csc_pkg::B1]
			| ck3_n[csc_pkg::B2]; // [R11]
		ck1_n[csc_pkg::B5] = p.dbl_bit_err; // [R12]
		ck1_n[csc_pkg::B6] = p.bad_clk_seq; // [R13]

		ck2_n = csc_pkg::BYTE_RST;
		ck2_n[csc_pkg::B0] = multi(p.mnt_decode); // [R14]
		ck2_n[csc_pkg::B1] = multi(p.ring_gates); // [R15]
		ck2_n[csc_pkg::B2] = |p.refresh_faults; // [R16]
		ck2_n[csc_pkg::B3] = p.start_req & p.stop_req; // [R17]
		ck2_n[csc_pkg::B4] = p.drc_par_err; // [R18]
		ck2_n[csc_pkg::B5] = p.inv_addr; // [R18]
		ck2_n[csc_pkg::B6] = p.cs_addr_par; // [R19]
		ck2_n[csc_pkg::B7] = p.cs_data_par; // [R19]

		any_new = (|ck1_n) | (|ck2_n) | (|ck3_n);

		// Read path
		ar_ok = s_axi_arvalid & q.arready;
		ridx = s_axi_araddr[7:2];
		release_rd = ar_ok & (ridx == csc_pkg::IDX_CK1) & q.frozen; // [R23]

		// Live tracking until a check freezes the snapshot
		if (!q.frozen || release_rd)
		begin
			d.fru = fru_n;
			d.fr3 = {p.cs_addr_hi, p.grp_dec[4], 4'h0}; // [R22] [R1]
			d.fr4 = {3'h0, p.ext_addr[4:0]}; // [R22]
			d.ck1 = ck1_n;
			d.ck2 = ck2_n;
			d.ck3 = {ck3_n[7:5], p.cpu_status}; // [R21]
			d.frozen = any_new; // [R23]
		end

		if (ar_ok)
		begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = csc_pkg::RESP_OKAY;
			d.rdata = csc_pkg::WORD_RST;
			case (ridx)
				csc_pkg::IDX_FRU: d.rdata[7:0] = q.fru;
				csc_pkg::IDX_CK1: d.rdata[7:0] = q.ck1;
				csc_pkg::IDX_CK2: d.rdata[7:0] = q.ck2;
				csc_pkg::IDX_CK3: d.rdata[7:0] = q.ck3;
				csc_pkg::IDX_FR3: d.rdata[7:0] = q.fr3;
				csc_pkg::IDX_FR4: d.rdata[7:0] = q.fr4;
				csc_pkg::IDX_SDI: d.rdata[7:0] = p.id_sw; // [R22]
				csc_pkg::IDX_SYM: d.rdata[15:0] = 16'h0000;
				csc_pkg::IDX_CTRL: d.rdata[csc_pkg::CTRL_INHIBIT] = q.inhibit;
				csc_pkg::IDX_STAT: d.rdata[csc_pkg::STAT_FROZEN] = q.frozen;
				default: d.rresp = csc_pkg::RESP_SLVERR;
			endcase
		end
		else if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end

		// Write path: address and data in either order
		if (s_axi_awvalid && q.awready)
		begin
			d.awready = 1'b0;
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready)
		begin
			d.wready = 1'b0;
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb0 = s_axi_wstrb[0];
		end
		widx = q.awaddr[7:2];
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = csc_pkg::RESP_OKAY;
			case (widx)
				csc_pkg::IDX_CTRL:
				begin
					if (q.wstrb0)
						d.inhibit = q.wdata[csc_pkg::CTRL_INHIBIT];
				end
				csc_pkg::IDX_FRU, csc_pkg::IDX_CK1, csc_pkg::IDX_CK2,
				csc_pkg::IDX_CK3, csc_pkg::IDX_FR3, csc_pkg::IDX_FR4,
				csc_pkg::IDX_SDI, csc_pkg::IDX_SYM, csc_pkg::IDX_STAT:
					d.bresp = csc_pkg::RESP_OKAY;
				default: d.bresp = csc_pkg::RESP_SLVERR;
			endcase
		end
		else if (q.bvalid && s_axi_bready)
		begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
			// Zeroed ALU bus would read as bad parity and freeze a false check
			q.sync1.alu_bus <= csc_pkg::ALU_IDLE;
			q.sync2.alu_bus <= csc_pkg::ALU_IDLE;
		end
		else
			q <= d;
	end

	assign sense_frozen = q.frozen;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;

	// Checks on captured state
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_alu_t0_parity: assert property ( // [R6]
		!q.frozen && q.sync2.t0 && ~(^q.sync2.alu_bus) |=> q.ck1[csc_pkg::B0] && q.frozen)
		else $error("ALU parity at time zero not captured");
	a_ext_addr_par: assert property ( // [R8]
		!q.frozen && !q.sync2.t0 |=> !q.ck1[csc_pkg::B1] || $past(q.frozen))
		else $error("Address parity flagged outside time zero");
	a_inhibit_prop: assert property ( // [R7]
		!q.frozen && !q.inhibit && q.sync2.in_par_err |=> q.ck1[csc_pkg::B2])
		else $error("Input parity did not propagate");
	a_chip_summary: assert property ( // [R11]
		(|q.ck3[7:5]) |-> q.ck1[csc_pkg::B4])
		else $error("Chip summary missing");
	a_ring_overlap: assert property ( // [R15]
		!q.frozen && $countones(q.sync2.ring_gates) > 1 |=> q.ck2[csc_pkg::B1])
		else $error("Ring gate overlap not flagged");
	a_start_stop: assert property ( // [R17]
		!q.frozen && q.sync2.start_req && q.sync2.stop_req |=> q.ck2[csc_pkg::B3])
		else $error("Start with stop not flagged");
	a_unused_bit: assert property ( // [R13]
		!q.ck1[csc_pkg::B7])
		else $error("Unused bit set");
	a_snapshot_hold: assert property ( // [R23]
		q.frozen && !(ar_ok && ridx == csc_pkg::IDX_CK1) |=> $stable(q.ck1) && $stable(q.fr4)
		&& $stable(q.fru) && q.frozen)
		else $error("Snapshot changed before read");
	a_ext_capture: assert property ( // [R22]
		!q.frozen |=> q.fr4[4:0] == $past(q.sync2.ext_addr[4:0]))
		else $error("Address not tracked");
	a_id_read: assert property ( // [R22]
		ar_ok && ridx == csc_pkg::IDX_SDI ##1 q.sync2.id_sw == $past(q.sync2.id_sw)
		|-> q.rvalid && q.rdata[7:0] == $past(q.sync2.id_sw))
		else $error("Identifier read wrong");
	a_read_answer: assert property (
		ar_ok |=> q.rvalid [*1] ##0 !q.arready)
		else $error("Read not answered next cycle");

	c_freeze: cover property (!q.frozen ##1 q.frozen);
	c_release: cover property (release_rd ##1 !q.frozen);
	c_write_ctrl: cover property (q.bvalid && q.inhibit);

endmodule

`default_nettype wire

// ### tb/csc_sc_model.sv
`timescale 1ns/1ps
`default_nettype none

module csc_sc_model (
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Released addresses and write data show the inverse of their last value; wstrb keeps its value
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !ok; n++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
			begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready)
			begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid)
			begin
				r = bresp;
				ok = 1;
				bready <= 1'b0;
			end
		end
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !ok; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
			begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid)
			begin
				d = rdata;
				r = rresp;
				ok = 1;
				rready <= 1'b0;
			end
		end
		@(posedge aclk);
	endtask
endmodule

`default_nettype wire

// ### tb/csc_sense_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module csc_sense_capture_tb_top;
	localparam logic [1:0] OKR = csc_pkg::RESP_OKAY;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	csc_pkg::csc_pins_t pins;
	csc_pkg::csc_pins_t p;
	logic frozen, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int err_count = 0;
	int cmp_count = 0;
	logic [23:0] exp_t [23] = '{24'hA00000, 24'h400000, 24'h200000, 24'h000000,
		24'h100000, 24'h100000, 24'h040000, 24'h020000, 24'h008000, 24'h004000,
		24'h002000, 24'h002000, 24'h002000, 24'h001000, 24'h000800, 24'h000400,
		24'h000200, 24'h000100, 24'h080080, 24'h080040, 24'h080020, 24'h080020, 24'h080020};

	always #5 aclk = ~aclk;

	csc_sense_capture uut (.aclk, .aresetn, .pins, .sense_frozen(frozen),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	csc_sc_model sc (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);

	function automatic logic [7:0] ba(input logic [5:0] i);
		return {i, 2'b00};
	endfunction

	function automatic csc_pkg::csc_pins_t base();
		csc_pkg::csc_pins_t q;
		q = '0;
		q.t0 = 1'b1;
		q.alu_bus = 9'h001;
		q.ext_addr = 6'h31;
		q.cs_addr_hi = 3'h5;
		q.grp_dec = 5'h10;
		q.id_sw = 8'h5A;
		return q;
	endfunction

	// Pin set for test case k; case 3 raises no check
	function automatic csc_pkg::csc_pins_t mk(input int k);
		csc_pkg::csc_pins_t q;
		q = base();
		q.t0 = !(k == 2 || k == 3);
		case (k)
			0, 2: q.alu_bus = 9'h000;
			1, 3: q.ext_addr = 6'h30;
			4: q.ls_addr_chk = 1'b1;
			5: q.gate_chk = 1'b1;
			6: q.dbl_bit_err = 1'b1;
			7: q.bad_clk_seq = 1'b1;
			8: q.mnt_decode = 4'h3;
			9: q.ring_gates = 4'h5;
			10, 11, 12: q.refresh_faults = 3'(1 << (k - 10));
			13: {q.start_req, q.stop_req} = 2'h3;
			14: q.drc_par_err = 1'b1;
			15: q.inv_addr = 1'b1;
			16: q.cs_addr_par = 1'b1;
			17: q.cs_data_par = 1'b1;
			18: q.fetch_in_par = 1'b1;
			19: q.reg_in_par = 1'b1;
			default: q.cpu_faults = 3'(1 << (k - 20));
		endcase
		return q;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("Compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic fin(input bit ok);
		if (!ok)
		begin
			err_count++;
			end_sim();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bit ok;
		sc.rd(a, d, r, ok);
		fin(ok);
		chk("read data", d, {24'h000000, e});
		chk("read resp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit ok;
		sc.wr(a, {24'h000000, d}, r, ok);
		fin(ok);
		chk("write resp", {30'h0, r}, {30'h0, er});
	endtask

	task automatic hold(input csc_pkg::csc_pins_t q, input int n);
		pins <= q;
		repeat (n) @(posedge aclk);
	endtask

	initial
	begin
		pins = base();
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ba(csc_pkg::IDX_SYM), 8'h00, OKR);
		rd(ba(csc_pkg::IDX_SDI), 8'h5A, OKR);
		rd(8'hC0, 8'h00, csc_pkg::RESP_SLVERR);
		wrc(8'hC0, 8'h01, csc_pkg::RESP_SLVERR);
		wrc(ba(csc_pkg::IDX_CK1), 8'hFF, OKR);
		rd(ba(csc_pkg::IDX_CK1), 8'h00, OKR);
		for (int i = 0; i < 8; i++)
		begin
			p = base();
			if (i < 4)
				p.grp_dec[i] = 1'b1;
			{p.ext_op, p.solid_chk, p.store_cycle, p.ros_exec} = 4'(8'h80 >> i);
			hold(p, 4);
			rd(ba(csc_pkg::IDX_FRU), 8'h80 >> i, OKR);
			hold(base(), 4);
			rd(ba(csc_pkg::IDX_CK1), 8'h00, OKR);
		end
		for (int k = 0; k < 23; k++)
		begin
			hold(mk(k), 5);
			chk("frozen", frozen, exp_t[k] != 0);
			hold(base(), 4);
			rd(ba(csc_pkg::IDX_CK2), exp_t[k][15:8], OKR);
			rd(ba(csc_pkg::IDX_CK3), exp_t[k][7:0], OKR);
			rd(ba(csc_pkg::IDX_CK1), exp_t[k][23:16], OKR);
			rd(ba(csc_pkg::IDX_CK1), 8'h00, OKR);
		end
		hold(mk(6), 5);
		p = base();
		p.grp_dec = 5'h0F;
		p.cs_addr_hi = 3'h0;
		p.ext_addr = 6'h01;
		hold(p, 4);
		rd(ba(csc_pkg::IDX_FRU), 8'h00, OKR);
		rd(ba(csc_pkg::IDX_FR3), 8'hB0, OKR);
		rd(ba(csc_pkg::IDX_FR4), 8'h11, OKR);
		rd(ba(csc_pkg::IDX_STAT), 8'h01, OKR);
		rd(ba(csc_pkg::IDX_CK1), 8'h04, OKR);
		rd(ba(csc_pkg::IDX_FR3), 8'h00, OKR);
		rd(ba(csc_pkg::IDX_FR4), 8'h01, OKR);
		rd(ba(csc_pkg::IDX_FRU), 8'hF0, OKR);
		wrc(ba(csc_pkg::IDX_CTRL), 8'h01, OKR);
		rd(ba(csc_pkg::IDX_CTRL), 8'h01, OKR);
		p = base();
		p.in_par_err = 1'b1;
		hold(p, 5);
		chk("frozen", frozen, 1'b0);
		hold(base(), 2);
		wrc(ba(csc_pkg::IDX_CTRL), 8'h00, OKR);
		hold(p, 5);
		chk("frozen", frozen, 1'b1);
		hold(base(), 4);
		rd(ba(csc_pkg::IDX_CK1), 8'hA0, OKR);
		end_sim();
	end
endmodule

`default_nettype wire
